// *** gpcde_ports.sv ***
// Port C, D and E pin logic with data latches, direction registers, and pullup registers on ports C and D only
`timescale 1ns/1ps
`default_nettype none

module gpcde_ports #(
	parameter int PC_W = 7,
	parameter int PD_W = 8,
	parameter int PE_W = 6
) (
	input  wire logic                       sys_clk_i,
	input  wire logic                       rstn_i,
	input  wire gpcde_pkg::gpcde_cpu_req_t  cpu_req_i,
	output logic [gpcde_pkg::DATA_W-1:0]    cpu_rdata_o,
	input  wire logic [PC_W-1:0]            pc_pin_i,
	output logic [PC_W-1:0]                 pc_pin_o,
	output logic [PC_W-1:0]                 pc_pin_oe_o,
	output logic [PC_W-1:0]                 pc_pullup_o,
	input  wire logic [PD_W-1:0]            pd_pin_i,
	output logic [PD_W-1:0]                 pd_pin_o,
	output logic [PD_W-1:0]                 pd_pin_oe_o,
	output logic [PD_W-1:0]                 pd_pullup_o,
	input  wire logic [PE_W-1:0]            pe_pin_i,
	output logic [PE_W-1:0]                 pe_pin_o,
	output logic [PE_W-1:0]                 pe_pin_oe_o,
	input  wire logic                       spi_enable_bit_i,
	input  wire logic                       spi_master_select_i,
	input  wire logic                       serial_module_enable_i,
	input  wire logic [3:0]                 timer_edge_level_sel_b_i,
	input  wire logic [3:0]                 timer_edge_level_sel_a_i,
	input  wire gpcde_pkg::gpcde_pd_periph_t pd_periph_i,
	input  wire gpcde_pkg::gpcde_pe_periph_t pe_periph_i
);

	localparam int DW = gpcde_pkg::DATA_W;

	logic          rst_meta_r;
	logic          rst_sync_r;
	logic          rstn;

	// Reset release through two flops
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	assign rstn = rst_sync_r;

	logic           sel_pc;
	logic           sel_pd;
	logic           sel_pe;
	logic           sel_pcd;
	logic           sel_pdd;
	logic           sel_ped;
	logic           sel_pcu;
	logic           sel_pdu;

	always_comb begin
		sel_pc  = cpu_req_i.addr == gpcde_pkg::PORT_C_DATA_OFS;
		sel_pd  = cpu_req_i.addr == gpcde_pkg::PORT_D_DATA_OFS;
		sel_pe  = cpu_req_i.addr == gpcde_pkg::PORT_E_DATA_OFS;
		sel_pcd = cpu_req_i.addr == gpcde_pkg::PORT_C_DIR_OFS;
		sel_pdd = cpu_req_i.addr == gpcde_pkg::PORT_D_DIR_OFS;
		sel_ped = cpu_req_i.addr == gpcde_pkg::PORT_E_DIR_OFS;
		sel_pcu = cpu_req_i.addr == gpcde_pkg::PORT_C_PULLUP_OFS;
		sel_pdu = cpu_req_i.addr == gpcde_pkg::PORT_D_PULLUP_OFS;
	end

	// Data latches: no reset, contents survive it
	logic [PC_W-1:0] pc_latch_r;
	logic [PC_W-1:0] pc_latch_nxt;
	logic [PD_W-1:0] pd_latch_r;
	logic [PD_W-1:0] pd_latch_nxt;
	logic [PE_W-1:0] pe_latch_r;
	logic [PE_W-1:0] pe_latch_nxt;

	always_comb begin
		pc_latch_nxt = pc_latch_r;
		pd_latch_nxt = pd_latch_r;
		pe_latch_nxt = pe_latch_r;
		if (cpu_req_i.wr && sel_pc) begin
			pc_latch_nxt = cpu_req_i.wdata[PC_W-1:0];
		end
		if (cpu_req_i.wr && sel_pd) begin
			pd_latch_nxt = cpu_req_i.wdata[PD_W-1:0];
		end
		if (cpu_req_i.wr && sel_pe) begin
			pe_latch_nxt = cpu_req_i.wdata[PE_W-1:0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		pc_latch_r <= pc_latch_nxt;
		pd_latch_r <= pd_latch_nxt;
		pe_latch_r <= pe_latch_nxt;
	end

	// Direction and pullup registers
	logic [PC_W-1:0] pc_dir_r;
	logic [PC_W-1:0] pc_dir_nxt;
	logic [PD_W-1:0] pd_dir_r;
	logic [PD_W-1:0] pd_dir_nxt;
	logic [PE_W-1:0] pe_dir_r;
	logic [PE_W-1:0] pe_dir_nxt;
	logic [PC_W-1:0] pc_pue_r;
	logic [PC_W-1:0] pc_pue_nxt;
	logic [PD_W-1:0] pd_pue_r;
	logic [PD_W-1:0] pd_pue_nxt;

	always_comb begin
		pc_dir_nxt = pc_dir_r;
		pd_dir_nxt = pd_dir_r;
		pe_dir_nxt = pe_dir_r;
		pc_pue_nxt = pc_pue_r;
		pd_pue_nxt = pd_pue_r;
		if (cpu_req_i.wr) begin
			if (sel_pcd) begin
				pc_dir_nxt = cpu_req_i.wdata[PC_W-1:0];
			end
			if (sel_pdd) begin
				pd_dir_nxt = cpu_req_i.wdata[PD_W-1:0];
			end
			if (sel_ped) begin
				pe_dir_nxt = cpu_req_i.wdata[PE_W-1:0];
			end
			if (sel_pcu) begin
				pc_pue_nxt = cpu_req_i.wdata[PC_W-1:0];
			end
			if (sel_pdu) begin
				pd_pue_nxt = cpu_req_i.wdata[PD_W-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn) begin
		if (!rstn) begin
			pc_dir_r <= gpcde_pkg::DIR_RESET[PC_W-1:0];
			pd_dir_r <= gpcde_pkg::DIR_RESET[PD_W-1:0];
			pe_dir_r <= gpcde_pkg::DIR_RESET[PE_W-1:0];
			pc_pue_r <= gpcde_pkg::PULLUP_RESET[PC_W-1:0];
			pd_pue_r <= gpcde_pkg::PULLUP_RESET[PD_W-1:0];
		end else begin
			pc_dir_r <= pc_dir_nxt;
			pd_dir_r <= pd_dir_nxt;
			pe_dir_r <= pe_dir_nxt;
			pc_pue_r <= pc_pue_nxt;
			pd_pue_r <= pd_pue_nxt;
		end
	end

	// Which pins a peripheral has taken
	logic [PD_W-1:0] pd_own;
	logic [PE_W-1:0] pe_own;

	always_comb begin
		pd_own = '0;
		pe_own = '0;
		for (int i = 0; i < gpcde_pkg::TIMER_CH_N; i++) begin
			pd_own[gpcde_pkg::TIMER_LO+i] = timer_edge_level_sel_b_i[i]
				| timer_edge_level_sel_a_i[i];
		end
		for (int i = gpcde_pkg::SPI_LO_BIT; i <= gpcde_pkg::SPI_HI_BIT; i++) begin
			pd_own[i] = spi_enable_bit_i;
		end
		// Port D bit 0 (SS) is taken only with SPI enabled and master select low
		pd_own[gpcde_pkg::SS_BIT] = spi_enable_bit_i & ~spi_master_select_i;
		for (int i = 0; i < gpcde_pkg::SERIAL_PINS; i++) begin
			pe_own[i] = serial_module_enable_i;
		end
	end

	// Pin drive, enable and pullup, registered
	logic [PC_W-1:0] pc_out_r;
	logic [PC_W-1:0] pc_oe_r;
	logic [PC_W-1:0] pc_pu_r;
	logic [PD_W-1:0] pd_out_r;
	logic [PD_W-1:0] pd_oe_r;
	logic [PD_W-1:0] pd_pu_r;
	logic [PE_W-1:0] pe_out_r;
	logic [PE_W-1:0] pe_oe_r;
	logic [PC_W-1:0] pc_out_nxt;
	logic [PC_W-1:0] pc_oe_nxt;
	logic [PC_W-1:0] pc_pu_nxt;
	logic [PD_W-1:0] pd_out_nxt;
	logic [PD_W-1:0] pd_oe_nxt;
	logic [PD_W-1:0] pd_pu_nxt;
	logic [PE_W-1:0] pe_out_nxt;
	logic [PE_W-1:0] pe_oe_nxt;

	always_comb begin
		pc_out_nxt = pc_latch_r;
		pc_oe_nxt  = pc_dir_r;
		pc_pu_nxt  = pc_pue_r & ~pc_dir_r;
		pd_out_nxt = pd_latch_r;
		pd_oe_nxt  = pd_dir_r;
		for (int i = 0; i < PD_W; i++) begin
			if (pd_own[i]) begin
				pd_out_nxt[i] = pd_periph_i.out[i];
				pd_oe_nxt[i]  = pd_periph_i.oe[i];
			end
		end
		pd_pu_nxt  = pd_pue_r & ~pd_dir_r & ~pd_oe_nxt;
		pe_out_nxt = pe_latch_r;
		pe_oe_nxt  = pe_dir_r;
		for (int i = 0; i < gpcde_pkg::SERIAL_PINS; i++) begin
			if (pe_own[i]) begin
				pe_out_nxt[i] = pe_periph_i.out[i];
				pe_oe_nxt[i]  = pe_periph_i.oe[i];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn) begin
		if (!rstn) begin
			pc_out_r <= '0;
			pc_oe_r  <= '0;
			pc_pu_r  <= '0;
			pd_out_r <= '0;
			pd_oe_r  <= '0;
			pd_pu_r  <= '0;
			pe_out_r <= '0;
			pe_oe_r  <= '0;
		end else begin
			pc_out_r <= pc_out_nxt;
			pc_oe_r  <= pc_oe_nxt;
			pc_pu_r  <= pc_pu_nxt;
			pd_out_r <= pd_out_nxt;
			pd_oe_r  <= pd_oe_nxt;
			pd_pu_r  <= pd_pu_nxt;
			pe_out_r <= pe_out_nxt;
			pe_oe_r  <= pe_oe_nxt;
		end
	end

	// Read mux; direction picks latch or pin even for taken pins
	logic [DW-1:0] pc_view;
	logic [DW-1:0] pd_view;
	logic [DW-1:0] pe_view;
	logic [DW-1:0] rdata_r;
	logic [DW-1:0] rdata_nxt;

	always_comb begin
		pc_view = '0;
		pd_view = '0;
		pe_view = '0;
		pc_view[PC_W-1:0] = (pc_dir_r & pc_latch_r) | (~pc_dir_r & pc_pin_i);
		pd_view[PD_W-1:0] = (pd_dir_r & pd_latch_r) | (~pd_dir_r & pd_pin_i);
		pe_view[PE_W-1:0] = (pe_dir_r & pe_latch_r) | (~pe_dir_r & pe_pin_i);
		rdata_nxt = gpcde_pkg::RDATA_RESET;
		if (cpu_req_i.rd) begin
			if (sel_pc) begin
				rdata_nxt = pc_view;
			end else if (sel_pd) begin
				rdata_nxt = pd_view;
			end else if (sel_pe) begin
				rdata_nxt = pe_view;
			end else if (sel_pcd) begin
				rdata_nxt[PC_W-1:0] = pc_dir_r;
			end else if (sel_pdd) begin
				rdata_nxt[PD_W-1:0] = pd_dir_r;
			end else if (sel_ped) begin
				rdata_nxt[PE_W-1:0] = pe_dir_r;
			end else if (sel_pcu) begin
				rdata_nxt[PC_W-1:0] = pc_pue_r;
			end else if (sel_pdu) begin
				rdata_nxt[PD_W-1:0] = pd_pue_r;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= gpcde_pkg::RDATA_RESET;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign cpu_rdata_o = rdata_r;
	assign pc_pin_o    = pc_out_r;
	assign pc_pin_oe_o = pc_oe_r;
	assign pc_pullup_o = pc_pu_r;
	assign pd_pin_o    = pd_out_r;
	assign pd_pin_oe_o = pd_oe_r;
	assign pd_pullup_o = pd_pu_r;
	assign pe_pin_o    = pe_out_r;
	assign pe_pin_oe_o = pe_oe_r;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn);

	pc_pullup_dir_a: assert property ((pc_pullup_o & pc_pin_oe_o) == '0)
		else $error("port C pullup on while driving");
	pd_pullup_dir_a: assert property (##1 (pd_pullup_o & $past(pd_dir_r)) == '0)
		else $error("port D pullup on while output");
	// Enables show the written value two edges on, owned pins masked as they were then
	pd_dir_write_a: assert property (cpu_req_i.wr && sel_pdd
		|=> ##1 (pd_pin_oe_o & ~$past(pd_own))
		== ($past(cpu_req_i.wdata, 2) & ~$past(pd_own)))
		else $error("port D direction write not seen on enables");
	pd_latch_wr_a: assert property (cpu_req_i.wr && sel_pd
		|=> pd_latch_r == $past(cpu_req_i.wdata))
		else $error("port D latch missed a write");
	pd_read_src_a: assert property (cpu_req_i.rd && sel_pd && pd_dir_r == 8'hFF
		|=> cpu_rdata_o == $past(pd_latch_r))
		else $error("port D read not from latch");
	pd_read_pin_a: assert property (cpu_req_i.rd && sel_pd && pd_dir_r == 8'h00
		|=> cpu_rdata_o == $past(pd_pin_i))
		else $error("port D read not from pins");
	pd_spi_off_a: assert property (!spi_enable_bit_i && !cpu_req_i.wr
		##1 !spi_enable_bit_i |=> pd_pin_oe_o[3:0] == $past(pd_dir_r[3:0], 2))
		else $error("SPI pins not general-purpose while SPI off");
	pe_upper_zero_a: assert property (cpu_req_i.rd && (sel_pe || sel_ped)
		|=> cpu_rdata_o[7:6] == 2'h0)
		else $error("port E upper bits not zero");
	pe_read_src_a: assert property (cpu_req_i.rd && sel_pe && pe_dir_r == 6'h3F
		|=> cpu_rdata_o[5:0] == $past(pe_latch_r))
		else $error("port E read not from latch");

	spi_take_c: cover property (spi_enable_bit_i && !spi_master_select_i ##2 pd_pin_oe_o[0]);
	pd_out_c: cover property (cpu_req_i.wr && sel_pdd ##2 pd_pin_oe_o != '0);
	pe_serial_c: cover property (serial_module_enable_i ##2 pe_pin_oe_o[0]);
	pc_pullup_c: cover property (pc_pullup_o != '0);

endmodule

`default_nettype wire

// *** gpcde_pkg.sv ***
// Package for the port C, D and E general-purpose I/O block
package gpcde_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	localparam logic [ADDR_W-1:0] PORT_C_DATA_OFS     = 16'h0002;
	localparam logic [ADDR_W-1:0] PORT_D_DATA_OFS     = 16'h0003;
	localparam logic [ADDR_W-1:0] PORT_E_DATA_OFS     = 16'h0008;
	localparam logic [ADDR_W-1:0] PORT_C_DIR_OFS      = 16'h0010;
	localparam logic [ADDR_W-1:0] PORT_D_DIR_OFS      = 16'h0011;
	localparam logic [ADDR_W-1:0] PORT_E_DIR_OFS      = 16'h0012;
	localparam logic [ADDR_W-1:0] PORT_C_PULLUP_OFS   = 16'h0013;
	localparam logic [ADDR_W-1:0] PORT_D_PULLUP_OFS   = 16'h0014;

	localparam logic [DATA_W-1:0] DIR_RESET    = 8'h00;
	localparam logic [DATA_W-1:0] PULLUP_RESET = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_RESET  = 8'h00;

	// Port D pin positions of shared functions, and the port E serial pin count
	localparam int SS_BIT      = 0;
	localparam int SPI_LO_BIT  = 1;
	localparam int SPI_HI_BIT  = 3;
	localparam int TIMER_LO    = 4;
	localparam int TIMER_CH_N  = 4;
	localparam int SERIAL_PINS = 2;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} gpcde_cpu_req_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} gpcde_pd_periph_t;

	typedef struct packed {
		logic [SERIAL_PINS-1:0] out;
		logic [SERIAL_PINS-1:0] oe;
	} gpcde_pe_periph_t;

endpackage

// *** gpcde_board.sv ***
// Board-side model of the pin levels seen by the port inputs
`timescale 1ns/1ps
`default_nettype none
module gpcde_board #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] out_i,
	input  wire logic [W-1:0] oe_i,
	input  wire logic [W-1:0] pullup_i,
	input  wire logic [W-1:0] float_i,
	output logic [W-1:0]      lvl_o
);
	// Undriven pins without pullup show the bench pattern, not the last level
	always_comb begin
		for (int i = 0; i < W; i++) begin
			lvl_o[i] = oe_i[i] ? out_i[i] : (pullup_i[i] ? 1'b1 : float_i[i]);
		end
	end
endmodule
`default_nettype wire

// *** tb_gpio_ports_c_d_e.sv ***
// Self-checking testbench for the port C, D and E block
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_ports_c_d_e;
	logic                        sys_clk_i = 1'b0;
	logic                        rstn_i = 1'b0;
	gpcde_pkg::gpcde_cpu_req_t   req = '0;
	gpcde_pkg::gpcde_pd_periph_t pd_per = '0;
	gpcde_pkg::gpcde_pe_periph_t pe_per = '0;
	logic                        spi_en = 1'b0;
	logic                        spi_mst = 1'b0;
	logic                        sci_en = 1'b0;
	logic [3:0]                  sel_a = 4'h0;
	logic [3:0]                  sel_b = 4'h0;
	logic [6:0]                  pc_fl = 7'h00;
	logic [7:0]                  pd_fl = 8'h00;
	logic [5:0]                  pe_fl = 6'h00;
	logic [6:0]                  pc_lvl, pc_o, pc_oe, pc_pu;
	logic [7:0]                  pd_lvl, pd_o, pd_oe, pd_pu, rdata;
	logic [5:0]                  pe_lvl, pe_o, pe_oe;
	logic [7:0]                  exp_q[$];
	logic [7:0]                  dv, dd, dp, df;
	logic                        pend = 1'b0;
	logic [31:0]                 seed = 32'h0000_0029;
	int                          bad_count = 0;
	int                          n_tests = 0;
	int                          cyc = 0;
	int                          p;
	logic [15:0] dat_a [3] = '{gpcde_pkg::PORT_C_DATA_OFS, gpcde_pkg::PORT_D_DATA_OFS,
		gpcde_pkg::PORT_E_DATA_OFS};
	logic [15:0] dir_a [3] = '{gpcde_pkg::PORT_C_DIR_OFS, gpcde_pkg::PORT_D_DIR_OFS,
		gpcde_pkg::PORT_E_DIR_OFS};
	logic [15:0] pu_a [3] = '{gpcde_pkg::PORT_C_PULLUP_OFS, gpcde_pkg::PORT_D_PULLUP_OFS,
		16'h0015};
	logic [7:0]  msk [3] = '{8'h7F, 8'hFF, 8'h3F};

	gpcde_ports dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cpu_req_i(req),
		.cpu_rdata_o(rdata), .pc_pin_i(pc_lvl), .pc_pin_o(pc_o), .pc_pin_oe_o(pc_oe),
		.pc_pullup_o(pc_pu), .pd_pin_i(pd_lvl), .pd_pin_o(pd_o), .pd_pin_oe_o(pd_oe),
		.pd_pullup_o(pd_pu), .pe_pin_i(pe_lvl), .pe_pin_o(pe_o), .pe_pin_oe_o(pe_oe),
		.spi_enable_bit_i(spi_en), .spi_master_select_i(spi_mst),
		.serial_module_enable_i(sci_en), .timer_edge_level_sel_b_i(sel_b),
		.timer_edge_level_sel_a_i(sel_a), .pd_periph_i(pd_per), .pe_periph_i(pe_per));
	gpcde_board #(.W(7)) brd_c (.out_i(pc_o), .oe_i(pc_oe), .pullup_i(pc_pu),
		.float_i(pc_fl), .lvl_o(pc_lvl));
	gpcde_board #(.W(8)) brd_d (.out_i(pd_o), .oe_i(pd_oe), .pullup_i(pd_pu),
		.float_i(pd_fl), .lvl_o(pd_lvl));
	gpcde_board #(.W(6)) brd_e (.out_i(pe_o), .oe_i(pe_oe), .pullup_i(6'h00),
		.float_i(pe_fl), .lvl_o(pe_lvl));

	always #2.5 sys_clk_i = ~sys_clk_i;

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task complete_run;
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask

	task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge sys_clk_i);
		req <= '0;
	endtask

	task rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask

	task settle;
		repeat (3) @(posedge sys_clk_i);
		#1;
	endtask

	// Read results are registered at the taking edge and checked one cycle later
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (pend)
			chk("read data", exp_q.pop_front(), rdata);
		pend <= req.rd;
		if (cyc == 5000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		repeat (5) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		for (int i = 0; i < 3; i++) begin
			rd(dir_a[i], 8'h00);
			rd(pu_a[i], 8'h00);
		end
		$display("Test reset values done");
		for (int k = 0; k < 12; k++) begin
			p = k % 3;
			dv = rnd();
			dd = rnd();
			dp = rnd();
			df = rnd();
			@(posedge sys_clk_i);
			pc_fl <= df[6:0];
			pd_fl <= df;
			pe_fl <= df[5:0];
			bus(1'b1, dat_a[p], dv);
			bus(1'b1, dir_a[p], dd);
			bus(1'b1, pu_a[p], dp);
			if (p == 2)
				dp = 8'h00;
			rd(dir_a[p], dd & msk[p]);
			rd(dat_a[p], msk[p] & ((dv & dd) | (~dd & (dp | df))));
			rd(pu_a[p], dp & msk[p]);
			settle();
			case (p)
				0: begin
					chk("c oe", dd & 8'h7F, {1'b0, pc_oe});
					chk("c pullup", dp & ~dd & 8'h7F, {1'b0, pc_pu});
					chk("c out", dv & dd & 8'h7F, {1'b0, pc_o & pc_oe});
				end
				1: begin
					chk("d oe", dd, pd_oe);
					chk("d pullup", dp & ~dd, pd_pu);
					chk("d out", dv & dd, pd_o & dd);
				end
				default: chk("e oe", dd & 8'h3F, {2'b00, pe_oe});
			endcase
		end
		$display("Test port registers done");
		dv = rnd();
		df = (rnd() & 8'hFE) | {7'h00, ~dv[0]};
		// Clear port D pullups so undriven pins show the float pattern
		bus(1'b1, pu_a[1], 8'h00);
		bus(1'b1, dat_a[1], dv);
		bus(1'b1, dir_a[1], 8'h00);
		@(posedge sys_clk_i);
		pd_per <= '{out: df, oe: 8'h05};
		pd_fl <= 8'h5A;
		spi_en <= 1'b1;
		settle();
		chk("spi oe", 8'h05, pd_oe);
		rd(dat_a[1], (df & 8'h05) | 8'h5A);
		bus(1'b1, dir_a[1], 8'hFF);
		settle();
		chk("spi oe dir", 8'hF5, pd_oe);
		rd(dat_a[1], dv);
		@(posedge sys_clk_i);
		spi_mst <= 1'b1;
		settle();
		chk("ss out", {7'h00, dv[0]}, {7'h00, pd_o[0]});
		chk("spi out", df & 8'h0E, pd_o & 8'h0E);
		@(posedge sys_clk_i);
		spi_en <= 1'b0;
		pd_per <= '0;
		settle();
		chk("gpio out", dv, pd_o);
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk_i);
			sel_a <= (i < 4) ? 4'h1 << i : 4'h0;
			sel_b <= (i < 4) ? 4'h0 : 4'h1 << (i - 4);
			settle();
			chk("timer oe", ~(8'h10 << (i % 4)), pd_oe);
		end
		@(posedge sys_clk_i);
		sel_b <= 4'h0;
		$display("Test shared port D pins done");
		bus(1'b1, dat_a[2], dv);
		bus(1'b1, dir_a[2], 8'h3F);
		@(posedge sys_clk_i);
		pe_per <= '{out: ~dv[1:0], oe: 2'b01};
		sci_en <= 1'b1;
		settle();
		chk("sci oe", 8'h3D, {2'b00, pe_oe});
		chk("sci out", {7'h00, ~dv[0]}, {7'h00, pe_o[0]});
		rd(dat_a[2], dv & 8'h3F);
		@(posedge sys_clk_i);
		sci_en <= 1'b0;
		settle();
		chk("e gpio", dv & 8'h3F, {2'b00, pe_o & pe_oe});
		$display("Test port E serial pins done");
		bus(1'b1, dat_a[1], dv);
		@(posedge sys_clk_i);
		rstn_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		settle();
		chk("oe after reset", 8'h00, pd_oe);
		bus(1'b1, dir_a[1], 8'hFF);
		rd(dat_a[1], dv);
		repeat (3) @(posedge sys_clk_i);
		$display("Test latch across reset done");
		complete_run();
	end
endmodule
`default_nettype wire
